/* rtl/gpab_pkg.sv */
// Constants for the four-bit bidirectional port and the eight-bit input port.
// Assumes a 32-bit APB slave on mclk. Register indices are scaled by four
// to form byte addresses.
//
// Function
// - Bidir data register holds pin outputs in bits 3..0, resets to F0.
// - Direction bit 1: port read returns the stored data bit.
// - Direction bit 0: port read returns the actual pin level.
// - Direction bit 1 makes the pin an output, 0 an input.
// - Direction and data act only while the pin is general-purpose.
// - Direction register resets to F0, so all pins start as inputs.
// - Direction register is write-only and reads as all ones.
// - Segment select 0000 gives general I/O, otherwise common outputs 4..1.
// - Pins float in reset and standby, hold in sleep/watch.
// - Input port has eight pins, no drivers, no direction control.
// - Input port read gives pin levels, analog-selected pins read 0.
// - Function select bit 3 is the only writable bit.
// - Select 0: pin 3 is plain input; 1: interrupt or timer input.
// - Function select register resets to F7.
// - Function select bits 7..4 and 2..0 read 1, ignore writes.
package gpab_pkg;

   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;

   // Printed offsets are register indices
   localparam logic [17:0] IDX_BIDIR_DATA = 18'h0FFDD;
   localparam logic [17:0] IDX_BIDIR_DIR = 18'h0FFED;
   localparam logic [17:0] IDX_IN_LEVELS = 18'h0FFDE;
   localparam logic [17:0] IDX_IN_FSEL = 18'h0FFEE;

   localparam logic [7:0] BIDIR_DATA_RST = 8'hF0;
   localparam logic [7:0] BIDIR_DIR_RST = 8'hF0;
   localparam logic [7:0] IN_FSEL_RST = 8'hF7;
   localparam logic [7:0] BIDIR_DIR_READ = 8'hFF;

   localparam int FSEL_IRQ_BIT = 3;
   localparam logic [3:0] SEG_GPIO = 4'h0;
   // Converter channel code of analog input 0; input n is this plus n
   localparam logic [3:0] ANALOG_BASE_CODE = 4'h4;

   localparam int SYNC_STAGES = 2;

endpackage : gpab_pkg

/* rtl/gpab_sync.sv */
// Two-flop synchroniser for pin levels.
// Assumes asynchronous inputs; only the last stage may be read.
`timescale 1ns/1ps
module gpab_sync #(
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_chk
      $error("gpab_sync: WIDTH must be at least 1");
   end

   // First stage feeds the second stage only
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule : gpab_sync

/* rtl/gpab_pin_cell.sv */
// Drive stage of one bidirectional port pin.
// Assumes mode and control inputs come from logic on mclk.
`timescale 1ns/1ps
module gpab_pin_cell (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic gp_mode,
   input wire logic dir,
   input wire logic data,
   input wire logic com_level,
   input wire logic standby,
   input wire logic hold,
   output logic pin_out,
   output logic pin_oe
);

   // Outputs floated in reset; registered so the pin never glitches
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else if (standby) begin
         pin_oe <= 1'b0;
      end else if (!hold) begin
         if (gp_mode) begin
            pin_out <= data;
            pin_oe <= dir;
         end else begin
            pin_out <= com_level;
            pin_oe <= 1'b1;
         end
      end
   end

endmodule : gpab_pin_cell

/* rtl/gpab_port.sv */
// Top of the port pair: APB register slave, bidirectional port drive and
// input port read-back with analog masking and pin 3 function routing.
// Assumes pins are asynchronous, mode and select inputs are on mclk.
`timescale 1ns/1ps
module gpab_port (
   input wire logic mclk,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gpab_pkg::ADDR_W-1:0] paddr,
   input wire logic [gpab_pkg::DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [gpab_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Bidirectional port pins
   input wire logic [3:0] bidir_port_pin_in,
   output logic [3:0] bidir_port_pin_out,
   output logic [3:0] bidir_port_pin_oe,
   // Shared LCD function
   input wire logic [3:0] segment_select_field,
   input wire logic [3:0] lcd_com_level,
   // Input port pins
   input wire logic [7:0] input_port_pin,
   // Shared converter function
   input wire logic [3:0] converter_channel_select,
   // Power modes
   input wire logic standby_mode,
   input wire logic hold_mode,
   // Pin 3 alternate function
   output logic pin3_interrupt_select,
   output logic timer_event_input
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [3:0] bidir_port_output_data_q;
   logic [3:0] bidir_port_direction_q;
   logic input_port_function_select_q;
   logic [3:0] bidir_sync;
   logic [7:0] in_sync;
   logic [7:0] analog_mask;
   logic [7:0] in_read;
   logic [3:0] bidir_read;
   logic gp_mode;
   logic setup;
   logic wr_en;
   logic addr_aligned;
   logic hit_data;
   logic hit_dir;
   logic hit_lvl;
   logic hit_fsel;
   logic mapped;
   logic [7:0] rd_byte;
   logic [gpab_pkg::DATA_W-1:0] prdata_q;
   logic pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   gpab_sync #(.WIDTH(4)) u_sync_a (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in(bidir_port_pin_in),
      .sync_out(bidir_sync)
   );

   gpab_sync #(.WIDTH(8)) u_sync_b (
      .mclk(mclk),
      .rst_n(rst_n),
      .async_in(input_port_pin),
      .sync_out(in_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   assign setup = psel && !penable;
   // Zero wait states keep the master's cost to two cycles per access
   assign pready = 1'b1;
   assign wr_en = psel && penable && pready && pwrite && pstrb[0];
   assign addr_aligned = (paddr[1:0] == 2'b00);
   assign hit_data = addr_aligned && (paddr[19:2] == gpab_pkg::IDX_BIDIR_DATA);
   assign hit_dir = addr_aligned && (paddr[19:2] == gpab_pkg::IDX_BIDIR_DIR);
   assign hit_lvl = addr_aligned && (paddr[19:2] == gpab_pkg::IDX_IN_LEVELS);
   assign hit_fsel = addr_aligned && (paddr[19:2] == gpab_pkg::IDX_IN_FSEL);
   assign mapped = hit_data || hit_dir || hit_lvl || hit_fsel;

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bidir_port_output_data_q <= gpab_pkg::BIDIR_DATA_RST[3:0];
      end else if (wr_en && hit_data) begin
         bidir_port_output_data_q <= pwdata[3:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bidir_port_direction_q <= gpab_pkg::BIDIR_DIR_RST[3:0];
      end else if (wr_en && hit_dir) begin
         bidir_port_direction_q <= pwdata[3:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         input_port_function_select_q <= gpab_pkg::IN_FSEL_RST[gpab_pkg::FSEL_IRQ_BIT];
      end else if (wr_en && hit_fsel) begin
         input_port_function_select_q <= pwdata[gpab_pkg::FSEL_IRQ_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bidirectional port drive

   assign gp_mode = (segment_select_field == gpab_pkg::SEG_GPIO);

   for (genvar i = 0; i < 4; i++) begin : g_pin
      gpab_pin_cell u_cell (
         .mclk(mclk),
         .rst_n(rst_n),
         .gp_mode(gp_mode),
         .dir(bidir_port_direction_q[i]),
         .data(bidir_port_output_data_q[i]),
         .com_level(lcd_com_level[i]),
         .standby(standby_mode),
         .hold(hold_mode),
         .pin_out(bidir_port_pin_out[i]),
         .pin_oe(bidir_port_pin_oe[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read-back

   // Output bits echo the latch, so a loaded pin cannot corrupt a read
   assign bidir_read = (bidir_port_direction_q & bidir_port_output_data_q)
                     | (~bidir_port_direction_q & bidir_sync);

   for (genvar n = 0; n < 8; n++) begin : g_analog
      assign analog_mask[n] = (converter_channel_select == gpab_pkg::ANALOG_BASE_CODE + 4'(n));
   end

   assign in_read = in_sync & ~analog_mask;

   always_comb begin
      rd_byte = 8'h00;
      if (hit_data) begin
         rd_byte = {gpab_pkg::BIDIR_DATA_RST[7:4], bidir_read};
      end else if (hit_dir) begin
         rd_byte = gpab_pkg::BIDIR_DIR_READ;
      end else if (hit_lvl) begin
         rd_byte = in_read;
      end else if (hit_fsel) begin
         rd_byte = gpab_pkg::IN_FSEL_RST;
         rd_byte[gpab_pkg::FSEL_IRQ_BIT] = input_port_function_select_q;
      end
   end

   // Read data captured in the setup cycle and held through the access
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h00000000 : {24'h000000, rd_byte};
         pslverr_q <= !mapped;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q && psel && penable;

   ////////////////////////////////////////////////////////////////////////////
   // Pin 3 alternate function

   // Inactive level held high while the pin serves as a plain input
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin3_interrupt_select <= 1'b1;
         timer_event_input <= 1'b1;
      end else if (input_port_function_select_q) begin
         pin3_interrupt_select <= in_sync[3];
         timer_event_input <= in_sync[3];
      end else begin
         pin3_interrupt_select <= 1'b1;
         timer_event_input <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   sequence s_setup_read_data;
      psel && !penable && !pwrite && hit_data;
   endsequence

   sequence s_fsel_write;
      psel && penable && pwrite && pstrb[0] && hit_fsel;
   endsequence

   sequence s_fsel_set;
      psel && penable && pwrite && pstrb[0] && hit_fsel && pwdata[gpab_pkg::FSEL_IRQ_BIT];
   endsequence

   sequence s_fsel_clear;
      psel && penable && pwrite && pstrb[0] && hit_fsel && !pwdata[gpab_pkg::FSEL_IRQ_BIT];
   endsequence

   a_data_reset: assert property (@(posedge mclk) !rst_n |=> bidir_port_output_data_q == 4'h0)
      else $error("bidir data not cleared by reset");

   a_read_out_latch: assert property (@(posedge mclk) disable iff (!rst_n)
      s_setup_read_data |=> ((prdata[3:0] & $past(bidir_port_direction_q))
         == ($past(bidir_port_output_data_q) & $past(bidir_port_direction_q))))
      else $error("output pin read did not return latch");

   a_read_in_pin: assert property (@(posedge mclk) disable iff (!rst_n)
      s_setup_read_data |=> ((prdata[7:0] & ~{4'h0, $past(bidir_port_direction_q)})
         == {4'hF, $past(bidir_sync) & ~$past(bidir_port_direction_q)}))
      else $error("input pin read did not return level");

   a_dir_reads_ones: assert property (@(posedge mclk) disable iff (!rst_n)
      psel && !penable && !pwrite && hit_dir |=> prdata == 32'h000000FF)
      else $error("direction register did not read all ones");

   a_gpio_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      gp_mode && !standby_mode && !hold_mode
         |=> bidir_port_pin_oe == $past(bidir_port_direction_q)
            && bidir_port_pin_out == $past(bidir_port_output_data_q))
      else $error("gpio drive does not follow registers");

   a_lcd_common: assert property (@(posedge mclk) disable iff (!rst_n)
      !gp_mode && !standby_mode && !hold_mode
         |=> bidir_port_pin_oe == 4'hF && bidir_port_pin_out == $past(lcd_com_level))
      else $error("common outputs not driven");

   a_standby_float: assert property (@(posedge mclk) disable iff (!rst_n)
      standby_mode |=> bidir_port_pin_oe == 4'h0)
      else $error("pins driven in standby");

   a_hold_retain: assert property (@(posedge mclk) disable iff (!rst_n)
      hold_mode && !standby_mode |=> $stable(bidir_port_pin_oe) && $stable(bidir_port_pin_out))
      else $error("pins changed while holding");

   a_analog_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      psel && !penable && !pwrite && hit_lvl |=> (prdata[7:0] & $past(analog_mask)) == 8'h00)
      else $error("analog pin did not read zero");

   a_fsel_fixed: assert property (@(posedge mclk) disable iff (!rst_n)
      psel && !penable && !pwrite && hit_fsel |=> (prdata[7:0] | 8'h08) == 8'hFF)
      else $error("fixed select bits not one");

   // Select bit lands one edge after the write, the outputs one edge later
   a_fsel_route: assert property (@(posedge mclk) disable iff (!rst_n)
      s_fsel_clear |-> ##2 (pin3_interrupt_select && timer_event_input))
      else $error("pin 3 not returned to plain input");

   a_fsel_set: assert property (@(posedge mclk) disable iff (!rst_n)
      s_fsel_set |-> ##2 (pin3_interrupt_select == $past(in_sync[3])
         && timer_event_input == $past(in_sync[3])))
      else $error("pin 3 not routed to alternate inputs");

   a_fsel_write: assert property (@(posedge mclk) disable iff (!rst_n)
      s_fsel_write |=> input_port_function_select_q == $past(pwdata[gpab_pkg::FSEL_IRQ_BIT]))
      else $error("function select bit not written");

   a_data_write: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_en && hit_data |=> bidir_port_output_data_q == $past(pwdata[3:0]))
      else $error("bidir data not written");

   a_dir_write: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_en && hit_dir |=> bidir_port_direction_q == $past(pwdata[3:0]))
      else $error("direction not written");

   // Low byte strobe gates every register write
   a_strobe_gate: assert property (@(posedge mclk) disable iff (!rst_n)
      psel && penable && pwrite && !pstrb[0]
         |=> $stable(bidir_port_output_data_q) && $stable(bidir_port_direction_q)
            && $stable(input_port_function_select_q))
      else $error("write taken without strobe");

   a_data_upper: assert property (@(posedge mclk) disable iff (!rst_n)
      s_setup_read_data |=> prdata[7:4] == 4'hF)
      else $error("unused data bits not one");

   a_levels_read: assert property (@(posedge mclk) disable iff (!rst_n)
      psel && !penable && !pwrite && hit_lvl |=> prdata[7:0] == ($past(in_sync) & ~$past(analog_mask)))
      else $error("input levels read wrong");

   a_dir_reset: assert property (@(posedge mclk)
      !rst_n |=> bidir_port_direction_q == 4'h0)
      else $error("direction not cleared by reset");

   a_fsel_reset: assert property (@(posedge mclk)
      !rst_n |=> !input_port_function_select_q)
      else $error("function select not cleared by reset");

   a_reset_float: assert property (@(posedge mclk)
      !rst_n |=> bidir_port_pin_oe == 4'h0)
      else $error("pins driven in reset");

   // Error flag only shows in the access phase of an unmapped access
   a_err_unmapped: assert property (@(posedge mclk) disable iff (!rst_n)
      (psel && !penable && !mapped) ##1 (psel && penable) |-> pslverr)
      else $error("unmapped access not flagged");

endmodule : gpab_port

/* sim/gpab_board.sv */
// Board model: external drivers on the four bidirectional pins.
// Assumes the port's drive stage resolves against a board level.
`timescale 1ns/1ps
module gpab_board (
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   input wire logic [3:0] ext_level,
   output logic [3:0] pin_level
);
   ////////////////////////////////////////////////////////////////
   // Port wins where it drives; board level elsewhere
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_level[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
      end
   end
endmodule : gpab_board

/* sim/tb_gpab_port.sv */
// Self-checking bench for the port pair.
// Assumes zero-wait APB and two-flop pin synchronisers.
`timescale 1ns/1ps
module tb_gpab_port;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [19:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] pin_in, pin_out, pin_oe;
   logic [3:0] seg = 4'h0;
   logic [3:0] com = 4'h0;
   logic [3:0] ext = 4'hA;
   logic [3:0] chsel = 4'h0;
   logic [7:0] inp = 8'h00;
   logic standby = 1'b0;
   logic hold = 1'b0;
   logic irq_sel, tmr_ev;
   logic [31:0] rd;
   logic err;
   int failures = 0;
   int checks_done = 0;

   gpab_port i_gpab_port (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bidir_port_pin_in(pin_in), .bidir_port_pin_out(pin_out), .bidir_port_pin_oe(pin_oe),
      .segment_select_field(seg), .lcd_com_level(com), .input_port_pin(inp),
      .converter_channel_select(chsel), .standby_mode(standby), .hold_mode(hold),
      .pin3_interrupt_select(irq_sel), .timer_event_input(tmr_ev));
   gpab_board i_gpab_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_level(pin_in));

   initial begin
      forever #25 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////
   task automatic test_done;
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   // Waits on pready; never assumes the answer time
   task automatic apb(input logic wr, input logic [17:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) failures++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic settle;
      repeat (3) @(posedge mclk);
      #1;
   endtask : settle

   ////////////////////////////////////////////////////////////////
   task automatic t_reset;
      apb(1'b0, gpab_pkg::IDX_BIDIR_DIR, 8'h00);
      chk(rd, 32'h000000FF, "dir read");
      apb(1'b0, gpab_pkg::IDX_IN_FSEL, 8'h00);
      chk(rd, 32'h000000F7, "fsel reset");
      apb(1'b0, gpab_pkg::IDX_BIDIR_DATA, 8'h00);
      chk(rd, 32'h000000FA, "data pins");
      chk(pin_oe, 4'h0, "oe after reset");
      chk(pin_out, 4'h0, "data after reset");
   endtask : t_reset

   task automatic t_dir;
      apb(1'b1, gpab_pkg::IDX_BIDIR_DATA, 8'h05);
      apb(1'b1, gpab_pkg::IDX_BIDIR_DIR, 8'h03);
      settle();
      chk(pin_oe, 4'h3, "oe");
      chk(pin_out[1:0], 2'h1, "out");
      apb(1'b0, gpab_pkg::IDX_BIDIR_DATA, 8'h00);
      chk(rd, 32'h000000F9, "mixed read");
      apb(1'b0, gpab_pkg::IDX_BIDIR_DIR, 8'h00);
      chk(rd, 32'h000000FF, "dir still ones");
      apb(1'b0, 18'h00010, 8'h00);
      chk({31'h0, err}, 32'h1, "unmapped err");
      pstrb <= 4'h0;
      apb(1'b1, gpab_pkg::IDX_BIDIR_DATA, 8'h0A);
      pstrb <= 4'hF;
      apb(1'b0, gpab_pkg::IDX_BIDIR_DATA, 8'h00);
      chk(rd, 32'h000000F9, "strobe off");
   endtask : t_dir

   // Common outputs override direction bits
   task automatic t_lcd;
      seg <= 4'h3;
      com <= 4'h6;
      settle();
      chk(pin_oe, 4'hF, "lcd oe");
      chk(pin_out, 4'h6, "lcd out");
      @(posedge mclk);
      seg <= gpab_pkg::SEG_GPIO;
      settle();
      chk(pin_oe, 4'h3, "gpio back");
   endtask : t_lcd

   task automatic t_power;
      @(posedge mclk);
      hold <= 1'b1;
      apb(1'b1, gpab_pkg::IDX_BIDIR_DATA, 8'h02);
      settle();
      chk(pin_out[1:0], 2'h1, "hold keeps");
      @(posedge mclk);
      hold <= 1'b0;
      standby <= 1'b1;
      settle();
      chk(pin_oe, 4'h0, "standby float");
      @(posedge mclk);
      standby <= 1'b0;
      settle();
      chk(pin_out[1:0], 2'h2, "resume");
   endtask : t_power

   task automatic t_inport;
      @(posedge mclk);
      inp <= 8'h5A;
      settle();
      for (int n = 0; n < 8; n++) begin
         @(posedge mclk);
         chsel <= gpab_pkg::ANALOG_BASE_CODE + 4'(n);
         settle();
         apb(1'b0, gpab_pkg::IDX_IN_LEVELS, 8'h00);
         chk(rd, {24'h0, 8'h5A & ~(8'h01 << n)}, "analog mask");
      end
      chsel <= 4'h0;
      settle();
      apb(1'b0, gpab_pkg::IDX_IN_LEVELS, 8'h00);
      chk(rd, 32'h0000005A, "levels");
   endtask : t_inport

   task automatic t_fsel;
      apb(1'b1, gpab_pkg::IDX_IN_FSEL, 8'h08);
      apb(1'b0, gpab_pkg::IDX_IN_FSEL, 8'h00);
      chk(rd, 32'h000000FF, "fsel set");
      inp <= 8'h52;
      settle();
      chk({irq_sel, tmr_ev}, 2'h0, "pin3 routed");
      apb(1'b1, gpab_pkg::IDX_IN_FSEL, 8'h00);
      apb(1'b0, gpab_pkg::IDX_IN_FSEL, 8'h00);
      chk(rd, 32'h000000F7, "fixed bits");
      settle();
      chk({irq_sel, tmr_ev}, 2'h3, "pin3 idle");
   endtask : t_fsel

   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge mclk);
      #1;
      chk(pin_oe, 4'h0, "oe in reset");
      @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_dir();
      t_lcd();
      t_power();
      t_inport();
      t_fsel();
      test_done();
   end

   // Whole run is under two hundred cycles
   initial begin
      #200000;
      failures++;
      test_done();
   end
endmodule : tb_gpab_port
